// File: design/cpdi_pkg.sv
/*
 * Constants for the code-protect and device information block: word widths,
 * program-space addresses of the identification and factory areas, field
 * positions and fixed values.
 * Assumes a 14-bit program word and a 16-bit program address.
 */
package cpdi_pkg;

   localparam int                WORD_W            = 14;
   localparam int                ADDR_W            = 16;
   typedef logic [WORD_W-1:0]    cpdi_word_t;
   typedef logic [ADDR_W-1:0]    cpdi_addr_t;

   // User ID words
   localparam cpdi_addr_t        USER_ID_FIRST     = 16'h8000;
   localparam cpdi_addr_t        USER_ID_LAST      = 16'h8003;
   localparam int                USER_ID_CNT       = 4;
   localparam int                USER_ID_IDX_W     = 2;

   // Identification words
   localparam cpdi_addr_t        REV_ID_ADDR       = 16'h8005;
   localparam cpdi_addr_t        DEV_ID_ADDR       = 16'h8006;
   localparam logic [1:0]        REV_FIXED_BITS    = 2'h2;
   localparam int                REV_FIXED_LSB     = 12;
   localparam int                MAJOR_LSB         = 6;
   localparam int                REV_FIELD_W       = 6;

   // Factory information area
   localparam cpdi_addr_t        INFO_FIRST        = 16'h8100;
   localparam cpdi_addr_t        INFO_LAST         = 16'h811F;
   localparam int                INFO_WORDS        = 32;
   localparam int                INFO_IDX_W        = 5;
   localparam logic [4:0]        UNIQUE_LAST_IDX   = 5'h08;
   localparam logic [4:0]        UNIQUE_RSVD_IDX   = 5'h09;
   localparam logic [4:0]        CUST_FIRST_IDX    = 5'h0A;
   localparam logic [4:0]        CUST_LAST_IDX     = 5'h11;
   localparam logic [4:0]        TEMP_LOW_IDX      = 5'h13;
   localparam logic [4:0]        TEMP_HIGH_IDX     = 5'h16;
   localparam logic [4:0]        ADC_REF1_IDX      = 5'h18;
   localparam logic [4:0]        ADC_REF2_IDX      = 5'h19;
   localparam logic [4:0]        ADC_REF4_IDX      = 5'h1A;
   localparam logic [4:0]        CMP_REF1_IDX      = 5'h1B;
   localparam logic [4:0]        CMP_REF2_IDX      = 5'h1C;
   localparam logic [4:0]        CMP_REF4_IDX      = 5'h1D;

   // Values for unprogrammed and absent words
   localparam cpdi_word_t        ERASED_WORD       = 14'h3FFF;
   localparam cpdi_word_t        PROTECTED_WORD    = 14'h0000;
   localparam cpdi_word_t        UNASSIGNED_WORD   = 14'h3FFF;
   localparam cpdi_word_t        CP_UNUSED_ONES    = 14'h3FFE;
   localparam int                CP_BIT            = 0;

   // Region selection for self-writes
   typedef enum logic [1:0] {
      CPDI_REG_APP,
      CPDI_REG_STORE,
      CPDI_REG_BOOT,
      CPDI_REG_CFG
   } cpdi_region_e;

endpackage

// File: design/cpdi_user_id.sv
/*
 * Four user identification words, writable by the application and by an
 * external tool, erased to all ones by a bulk erase.
 * Assumes callers have already applied protection gating.
 */
`timescale 1ns/10ps
module cpdi_user_id (
   input  wire logic                                   i_ref_clk,
   input  wire logic                                   i_rst_n,
   input  wire logic                                   i_wr,
   input  wire logic                                   i_bulk_erase,
   input  wire logic [cpdi_pkg::USER_ID_IDX_W-1:0]     i_idx,
   input  wire cpdi_pkg::cpdi_word_t                   i_wdata,
   output            cpdi_pkg::cpdi_word_t             o_rdata
);
   import cpdi_pkg::*;

   cpdi_word_t    words_q [USER_ID_CNT];

   // Bulk erase wins over a simultaneous write
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < USER_ID_CNT; k++) words_q[k] <= ERASED_WORD;
      end else if (i_bulk_erase) begin
         for (int k = 0; k < USER_ID_CNT; k++) words_q[k] <= ERASED_WORD;
      end else if (i_wr) begin
         words_q[i_idx] <= i_wdata; // [R6]
      end
   end

   assign o_rdata = words_q[i_idx];

endmodule

// File: design/cpdi_info_rom.sv
/*
 * Factory information area: 32 read-only words fixed at manufacture.
 * Contents arrive as parameters standing in for factory programming; there
 * is no write path, so no erase or write can reach them.
 */
`timescale 1ns/10ps
module cpdi_info_rom #(
   parameter logic [cpdi_pkg::INFO_WORDS*cpdi_pkg::WORD_W-1:0] INFO_IMAGE =
      {cpdi_pkg::INFO_WORDS{cpdi_pkg::UNASSIGNED_WORD}},
   parameter bit                                       LOW_VOLT = 1'b0
) (
   input  wire logic [cpdi_pkg::INFO_IDX_W-1:0]        i_idx,
   output            cpdi_pkg::cpdi_word_t             o_rdata
);
   import cpdi_pkg::*;

   wire  cpdi_word_t    raw_word;
   wire                 is_unassigned;
   wire                 is_absent;

   assign raw_word = INFO_IMAGE[i_idx*WORD_W +: WORD_W]; // [R13] [R15] [R16] [R17]

   // Reserved and unassigned words give a fixed value
   assign is_unassigned = (i_idx == UNIQUE_RSVD_IDX) ||
                          ((i_idx > CUST_LAST_IDX) && (i_idx < ADC_REF1_IDX) &&
                           (i_idx != TEMP_LOW_IDX) && (i_idx != TEMP_HIGH_IDX)) ||
                          (i_idx > CMP_REF4_IDX); // [R20]

   // Gain-4 references are not measured on low-voltage parts
   assign is_absent = LOW_VOLT && ((i_idx == ADC_REF4_IDX) || (i_idx == CMP_REF4_IDX)); // [R18]

   assign o_rdata = (is_unassigned || is_absent) ? UNASSIGNED_WORD : raw_word; // [R12]

endmodule

// File: design/cpdi_top.sv
/*
 * Code-protect gate and device information block. Two ports reach the
 * identification space: an external programming tool and the internal
 * memory-control path of the CPU. Program memory itself sits outside;
 * this block gates its external access and its self-writes.
 * Assumes one-cycle request strobes synchronous to i_ref_clk.
 */
// Summary of operation
// R1: Protection bit zero enables program protection
// R2: Protection word bits 13..1 read one
// R3: Protected: external writes blocked, reads zero
// R4: CPU reads always allowed; writes region-gated
// R5: Four region locks gate self-writes
// R6: User ID words 8000h-8003h read/write
// R7: Device ID at 8006h, read-only
// R8: Revision ID at 8005h, read-only
// R9: IDs and config readable by both ports; no config words are decoded here, other ID-space reads give 3FFFh
// R10: Revision bits 13..12 read binary 10
// R11: Revision major 11..6, minor 5..0
// R12: Factory area 8100h-811Fh read-only
// R13: Unique serial 8100h-8108h, 8109h reserved
// R14: Unique serial survives every erase
// R15: Customer serial 810Ah-8111h survives bulk erase
// R16: Temperature calibration at 8113h and 8116h
// R17: Reference millivolts at 8118h-811Dh
// R18: Low-voltage parts lack gain-4 references
// R19: Writes to read-only words ignored
// R20: Reserved factory words read constant
`timescale 1ns/10ps
module cpdi_top #(
   parameter cpdi_pkg::cpdi_word_t                     PART_CODE  = 14'h1234, // arbitrary
   parameter logic [cpdi_pkg::REV_FIELD_W-1:0]         MAJOR_REV  = 6'h01,
   parameter logic [cpdi_pkg::REV_FIELD_W-1:0]         MINOR_REV  = 6'h00,
   parameter bit                                       LOW_VOLT   = 1'b0,
   parameter logic [cpdi_pkg::INFO_WORDS*cpdi_pkg::WORD_W-1:0] INFO_IMAGE =
      {cpdi_pkg::INFO_WORDS{cpdi_pkg::UNASSIGNED_WORD}}
) (
   input  wire logic                                   i_ref_clk,
   input  wire logic                                   i_rst_n,
   // Configuration bits, stored elsewhere in configuration memory, and the bulk erase request
   input  wire logic                                   i_read_protect_n,
   input  wire logic                                   i_app_region_write_lock_n,
   input  wire logic                                   i_storage_region_write_lock_n,
   input  wire logic                                   i_boot_region_write_lock_n,
   input  wire logic                                   i_config_region_write_lock_n,
   input  wire logic                                   i_bulk_erase,
   // External tool port
   input  wire logic                                   i_ext_rd,
   input  wire logic                                   i_ext_wr,
   input  wire cpdi_pkg::cpdi_addr_t                   i_ext_addr,
   input  wire cpdi_pkg::cpdi_word_t                   i_ext_wdata,
   input  wire cpdi_pkg::cpdi_word_t                   i_ext_mem_rdata,
   output logic                                        o_ext_rvalid,
   output            cpdi_pkg::cpdi_word_t             o_ext_rdata,
   output logic                                        o_ext_mem_wr,
   // CPU memory-control port
   input  wire logic                                   i_cpu_rd,
   input  wire logic                                   i_cpu_wr,
   input  wire cpdi_pkg::cpdi_addr_t                   i_cpu_addr,
   input  wire cpdi_pkg::cpdi_word_t                   i_cpu_wdata,
   input  wire cpdi_pkg::cpdi_region_e                 i_cpu_region,
   input  wire cpdi_pkg::cpdi_word_t                   i_cpu_mem_rdata,
   output logic                                        o_cpu_rvalid,
   output            cpdi_pkg::cpdi_word_t             o_cpu_rdata,
   output logic                                        o_cpu_mem_wr,
   output logic                                        o_cpu_wr_blocked,
   // Program memory write data, shared by both writers, and the protection word view
   output            cpdi_pkg::cpdi_word_t             o_mem_wdata,
   output            cpdi_pkg::cpdi_word_t             o_cp_word
);
   import cpdi_pkg::*;

   // Address classes used by both ports
   function automatic logic is_user_id(input cpdi_addr_t a);
      return (a >= USER_ID_FIRST) && (a <= USER_ID_LAST);
   endfunction

   function automatic logic is_info(input cpdi_addr_t a);
      return (a >= INFO_FIRST) && (a <= INFO_LAST);
   endfunction

   function automatic logic is_ident_space(input cpdi_addr_t a);
      return a[ADDR_W-1];
   endfunction

   wire                 protect_on;
   wire  cpdi_word_t    cp_word_val;
   wire  cpdi_word_t    rev_word;
   wire  cpdi_word_t    dev_word;
   wire                 cpu_region_unlocked;
   wire                 ext_wr_ok;
   wire                 cpu_mem_wr_ok;
   wire                 ext_uid_wr;
   wire                 cpu_uid_wr;
   wire                 uid_wr;
   wire  cpdi_addr_t    sel_addr;
   wire  cpdi_word_t    uid_wdata;
   wire  cpdi_word_t    uid_rdata;
   wire  cpdi_word_t    info_rdata;
   wire  cpdi_word_t    ext_space_word;
   wire  cpdi_word_t    cpu_space_word;
   wire  cpdi_word_t    ident_word;
   wire                 ext_mem_wr_req;
   wire                 cpu_mem_wr_req;

   logic                ext_rvalid_q;
   logic                ext_rvalid_d;
   cpdi_word_t          ext_rdata_q;
   cpdi_word_t          ext_rdata_d;
   logic                cpu_rvalid_q;
   cpdi_word_t          cpu_rdata_q;
   cpdi_word_t          cpu_rdata_d;
   logic                ext_mem_wr_q;
   logic                cpu_mem_wr_q;
   logic                cpu_wr_blocked_q;
   cpdi_word_t          mem_wdata_q;
   cpdi_word_t          mem_wdata_d;
   cpdi_word_t          cp_word_q;

   // Protection word: only bit 0 is real, the rest read as ones
   assign protect_on  = ~i_read_protect_n; // [R1]
   assign cp_word_val = CP_UNUSED_ONES | {{(WORD_W-1){1'b0}}, i_read_protect_n}; // [R2]

   // Identification words are constants; nothing can write them
   assign rev_word = {REV_FIXED_BITS, MAJOR_REV, MINOR_REV}; // [R8] [R10] [R11]
   assign dev_word = PART_CODE; // [R7]

   // Region lock for CPU self-writes; active-low locks
   assign cpu_region_unlocked =
      (i_cpu_region == CPDI_REG_APP)   ? i_app_region_write_lock_n     :
      (i_cpu_region == CPDI_REG_STORE) ? i_storage_region_write_lock_n :
      (i_cpu_region == CPDI_REG_BOOT)  ? i_boot_region_write_lock_n    :
                                         i_config_region_write_lock_n; // [R5]

   // External writes die while protected
   assign ext_wr_ok     = i_ext_wr && !protect_on; // [R3]
   assign cpu_mem_wr_ok = cpu_region_unlocked; // [R4]

   // Writes to ID space land only in user ID words
   // A CPU access owns the shared index, so an ext write then is dropped
   assign ext_uid_wr = ext_wr_ok && is_user_id(i_ext_addr) && !(i_cpu_rd || i_cpu_wr);
   assign cpu_uid_wr = i_cpu_wr && is_user_id(i_cpu_addr); // [R6]
   assign uid_wr     = ext_uid_wr || cpu_uid_wr; // [R19]

   // CPU takes the shared word port when both ask in one cycle
   assign sel_addr  = (i_cpu_rd || i_cpu_wr) ? i_cpu_addr : i_ext_addr;
   assign uid_wdata = cpu_uid_wr ? i_cpu_wdata : i_ext_wdata;

   // Program memory write requests: ID space never reaches the array
   assign ext_mem_wr_req = ext_wr_ok && !is_ident_space(i_ext_addr); // [R19]
   assign cpu_mem_wr_req = i_cpu_wr && !is_ident_space(i_cpu_addr) && cpu_mem_wr_ok;

   cpdi_user_id u_user_id (
      .i_ref_clk    (i_ref_clk),
      .i_rst_n      (i_rst_n),
      .i_wr         (uid_wr),
      .i_bulk_erase (i_bulk_erase),
      .i_idx        (sel_addr[USER_ID_IDX_W-1:0]),
      .i_wdata      (uid_wdata),
      .o_rdata      (uid_rdata)
   );

   // No erase or write reaches the factory words
   cpdi_info_rom #(
      .INFO_IMAGE   (INFO_IMAGE),
      .LOW_VOLT     (LOW_VOLT)
   ) u_info_rom (
      .i_idx        (sel_addr[INFO_IDX_W-1:0]),
      .o_rdata      (info_rdata)
   ); // [R12] [R14] [R15]

   // Identification space decode for the selected address
   assign ident_word = is_user_id(sel_addr)  ? uid_rdata  :
                       (sel_addr == REV_ID_ADDR) ? rev_word   :
                       (sel_addr == DEV_ID_ADDR) ? dev_word   :
                       is_info(sel_addr)     ? info_rdata :
                                               UNASSIGNED_WORD; // [R9]

   // Port views: ID space from here, user space from the array
   assign ext_space_word = is_ident_space(i_ext_addr) ? ident_word : i_ext_mem_rdata;
   assign cpu_space_word = is_ident_space(i_cpu_addr) ? ident_word : i_cpu_mem_rdata;

   // External read: protected program memory returns zeros
   assign ext_rvalid_d = i_ext_rd && !(i_cpu_rd || i_cpu_wr);
   assign ext_rdata_d  = (protect_on && !is_ident_space(i_ext_addr)) ?
                         PROTECTED_WORD : ext_space_word; // [R3] [R9]
   assign cpu_rdata_d  = cpu_space_word; // [R4] [R9]
   assign mem_wdata_d  = cpu_mem_wr_req ? i_cpu_wdata : i_ext_wdata;

   // External answer registers; valid drops and data is held while idle
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_rvalid_q <= 1'b0;
         ext_rdata_q  <= PROTECTED_WORD;
      end else begin
         ext_rvalid_q <= ext_rvalid_d;
         if (ext_rvalid_d) ext_rdata_q <= ext_rdata_d;
      end
   end

   // CPU answer registers
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cpu_rvalid_q <= 1'b0;
         cpu_rdata_q  <= PROTECTED_WORD;
      end else begin
         cpu_rvalid_q <= i_cpu_rd;
         if (i_cpu_rd) cpu_rdata_q <= cpu_rdata_d;
      end
   end

   // Write strobes toward the program array, one cycle each
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_mem_wr_q     <= 1'b0;
         cpu_mem_wr_q     <= 1'b0;
         cpu_wr_blocked_q <= 1'b0;
         mem_wdata_q      <= ERASED_WORD;
      end else begin
         ext_mem_wr_q     <= ext_mem_wr_req && !cpu_mem_wr_req;
         cpu_mem_wr_q     <= cpu_mem_wr_req; // [R5]
         cpu_wr_blocked_q <= i_cpu_wr && !is_ident_space(i_cpu_addr) && !cpu_mem_wr_ok;
         mem_wdata_q      <= mem_wdata_d;
      end
   end

   // Protection word view, registered for a clean output
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) cp_word_q <= ERASED_WORD;
      else          cp_word_q <= cp_word_val; // [R2]
   end

   assign o_ext_rvalid     = ext_rvalid_q;
   assign o_ext_rdata      = ext_rdata_q;
   assign o_ext_mem_wr     = ext_mem_wr_q;
   assign o_cpu_rvalid     = cpu_rvalid_q;
   assign o_cpu_rdata      = cpu_rdata_q;
   assign o_cpu_mem_wr     = cpu_mem_wr_q;
   assign o_cpu_wr_blocked = cpu_wr_blocked_q;
   assign o_mem_wdata      = mem_wdata_q;
   assign o_cp_word        = cp_word_q;

endmodule

// File: tb/cpdi_checker.sv
/* Concurrent checks on the code-protect and device information block.
   Assumes it is bound to cpdi_top and sees only that module's ports. */
`timescale 1ns/10ps
module cpdi_checker import cpdi_pkg::*; (
   input wire logic                 i_ref_clk,
   input wire logic                 i_rst_n,
   input wire logic                 i_read_protect_n,
   input wire logic                 i_app_region_write_lock_n,
   input wire logic                 i_storage_region_write_lock_n,
   input wire logic                 i_boot_region_write_lock_n,
   input wire logic                 i_config_region_write_lock_n,
   input wire logic                 i_ext_rd,
   input wire logic                 i_ext_wr,
   input wire cpdi_pkg::cpdi_addr_t i_ext_addr,
   input wire logic                 i_cpu_rd,
   input wire logic                 i_cpu_wr,
   input wire cpdi_pkg::cpdi_addr_t i_cpu_addr,
   input wire cpdi_pkg::cpdi_region_e i_cpu_region,
   input wire logic                 o_ext_rvalid,
   input wire cpdi_pkg::cpdi_word_t o_ext_rdata,
   input wire logic                 o_ext_mem_wr,
   input wire logic                 o_cpu_rvalid,
   input wire logic                 o_cpu_mem_wr,
   input wire logic                 o_cpu_wr_blocked,
   input wire cpdi_pkg::cpdi_word_t o_cp_word
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Request decodes; a same-cycle CPU access drops an external read
   wire logic [3:0] lock_n = {i_config_region_write_lock_n, i_boot_region_write_lock_n,
                              i_storage_region_write_lock_n, i_app_region_write_lock_n};
   wire logic       locked = !lock_n[i_cpu_region];
   wire logic       ext_go = i_ext_rd && !i_cpu_rd && !i_cpu_wr;
   wire logic       ext_ok = i_ext_wr && i_read_protect_n && (i_ext_addr < 16'h8000);

   a_cp_fixed_ones: assert property (o_cp_word[13:1] == 13'h1FFF)
      else $error("protection word upper bits not all one");
   a_cp_bit_track: assert property ($past(i_rst_n) |-> o_cp_word[0] == $past(i_read_protect_n))
      else $error("protection bit does not follow its setting");
   a_ext_rd_answer: assert property (ext_go |=> o_ext_rvalid)
      else $error("external read not answered next cycle");
   a_ext_rvalid_cause: assert property (o_ext_rvalid |-> $past(ext_go))
      else $error("external read valid without a read");
   a_prot_rd_zero: assert property (ext_go && !i_read_protect_n && i_ext_addr < 16'h8000
      |=> o_ext_rdata == 14'h0000)
      else $error("protected external read not zero");
   a_ext_wr_cause: assert property (o_ext_mem_wr |-> $past(ext_ok))
      else $error("array write from a refused external write");
   a_ext_wr_lands: assert property (ext_ok && !i_cpu_wr |=> o_ext_mem_wr)
      else $error("allowed external write not issued");
   a_cpu_rd_free: assert property (i_cpu_rd |=> o_cpu_rvalid)
      else $error("cpu read not answered");
   a_region_gate: assert property (i_cpu_wr && i_cpu_addr < 16'h8000
      |=> o_cpu_wr_blocked == $past(locked) && o_cpu_mem_wr == !$past(locked))
      else $error("self write not gated by its region lock");
   a_blocked_cause: assert property (o_cpu_wr_blocked |-> $past(i_cpu_wr) && $past(locked))
      else $error("blocked pulse without a locked write");

   c_prot_read: cover property (ext_go && !i_read_protect_n);
   c_blocked: cover property (o_cpu_wr_blocked);
   c_ext_write: cover property (o_ext_mem_wr);
endmodule

bind cpdi_top cpdi_checker u_chk (.i_ref_clk, .i_rst_n, .i_read_protect_n,
   .i_app_region_write_lock_n, .i_storage_region_write_lock_n, .i_boot_region_write_lock_n,
   .i_config_region_write_lock_n, .i_ext_rd, .i_ext_wr, .i_ext_addr, .i_cpu_rd, .i_cpu_wr,
   .i_cpu_addr, .i_cpu_region, .o_ext_rvalid, .o_ext_rdata, .o_ext_mem_wr, .o_cpu_rvalid,
   .o_cpu_mem_wr, .o_cpu_wr_blocked, .o_cp_word);

// File: tb/cpdi_prog_array.sv
/* Behavioural program array standing behind the gate: 16 words, read
   combinationally, written on the strobes. Assumes addresses below 8000h. */
`timescale 1ns/10ps
module cpdi_prog_array import cpdi_pkg::*; (
   input  wire logic                 i_ref_clk,
   input  wire cpdi_pkg::cpdi_addr_t i_ext_addr,
   input  wire cpdi_pkg::cpdi_addr_t i_cpu_addr,
   input  wire logic                 i_ext_mem_wr,
   input  wire logic                 i_cpu_mem_wr,
   input  wire cpdi_pkg::cpdi_word_t i_mem_wdata,
   output      cpdi_pkg::cpdi_word_t o_ext_word,
   output      cpdi_pkg::cpdi_word_t o_cpu_word
);
   cpdi_word_t mem [16];
   cpdi_addr_t ea_q, ca_q;
   // Known seed so untouched words can be checked
   initial for (int i = 0; i < 16; i++) mem[i] = 14'h0100 + 14'(i);
   // Same-cycle data for either reader
   assign o_ext_word = mem[i_ext_addr[3:0]];
   assign o_cpu_word = mem[i_cpu_addr[3:0]];
   // Strobe lags its request by one cycle, so the address is kept one deep
   always @(posedge i_ref_clk) begin
      ea_q <= i_ext_addr;
      ca_q <= i_cpu_addr;
      if (i_cpu_mem_wr) mem[ca_q[3:0]] <= i_mem_wdata;
      else if (i_ext_mem_wr) mem[ea_q[3:0]] <= i_mem_wdata;
   end
endmodule

// File: tb/cpdi_tb_top.sv
/* Self-checking bench for the code-protect and device information block.
   Assumes the checker binds itself; the array model serves both ports. */
`timescale 1ns/10ps
module cpdi_tb_top;
   import cpdi_pkg::*;
   localparam cpdi_word_t PART = 14'h0ABC; // arbitrary
   localparam logic [5:0] MJR = 6'h2A;
   localparam logic [5:0] MNR = 6'h15;
   localparam cpdi_word_t REV = {2'h2, MJR, MNR};
   function automatic logic [447:0] make_img();
      for (int i = 0; i < 32; i++) make_img[i*14+:14] = 14'h0200 + 14'(i);
   endfunction
   localparam logic [447:0] IMG = make_img();
   // Reserved, unassigned and low-voltage absent words read erased
   function automatic cpdi_word_t exp_info(input int i);
      return (i inside {9, 18, 20, 21, 23, 26, 29, 30, 31}) ? 14'h3FFF : 14'h0200 + 14'(i);
   endfunction

   logic i_ref_clk = 1'b0, i_rst_n, i_read_protect_n, i_bulk_erase;
   logic i_app_region_write_lock_n, i_storage_region_write_lock_n;
   logic i_boot_region_write_lock_n, i_config_region_write_lock_n;
   logic i_ext_rd, i_ext_wr, i_cpu_rd, i_cpu_wr;
   cpdi_addr_t i_ext_addr, i_cpu_addr;
   cpdi_word_t i_ext_wdata, i_cpu_wdata, i_ext_mem_rdata, i_cpu_mem_rdata;
   cpdi_region_e i_cpu_region;
   logic o_ext_rvalid, o_ext_mem_wr, o_cpu_rvalid, o_cpu_mem_wr, o_cpu_wr_blocked;
   cpdi_word_t o_ext_rdata, o_cpu_rdata, o_mem_wdata, o_cp_word;
   int error_cnt = 0, checked = 0, cyc = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   cpdi_top #(.PART_CODE(PART), .MAJOR_REV(MJR), .MINOR_REV(MNR), .LOW_VOLT(1'b1),
              .INFO_IMAGE(IMG)) dut (.i_ref_clk, .i_rst_n, .i_read_protect_n,
      .i_app_region_write_lock_n, .i_storage_region_write_lock_n, .i_boot_region_write_lock_n,
      .i_config_region_write_lock_n, .i_bulk_erase, .i_ext_rd, .i_ext_wr, .i_ext_addr,
      .i_ext_wdata, .i_ext_mem_rdata, .o_ext_rvalid, .o_ext_rdata, .o_ext_mem_wr, .i_cpu_rd,
      .i_cpu_wr, .i_cpu_addr, .i_cpu_wdata, .i_cpu_region, .i_cpu_mem_rdata, .o_cpu_rvalid,
      .o_cpu_rdata, .o_cpu_mem_wr, .o_cpu_wr_blocked, .o_mem_wdata, .o_cp_word);
   cpdi_prog_array u_arr (.i_ref_clk, .i_ext_addr, .i_cpu_addr, .i_ext_mem_wr(o_ext_mem_wr),
      .i_cpu_mem_wr(o_cpu_mem_wr), .i_mem_wdata(o_mem_wdata), .o_ext_word(i_ext_mem_rdata),
      .o_cpu_word(i_cpu_mem_rdata));

   task automatic wrap_up();
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input cpdi_word_t seen, input cpdi_word_t exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Drops every strobe for one cycle between bursts
   task automatic idle();
      {i_ext_rd, i_ext_wr, i_cpu_rd, i_cpu_wr} = 4'h0;
      @(negedge i_ref_clk);
   endtask
   // Returns at the falling edge where the answer stands; strobes stay up
   task automatic req(input bit cpu, input bit wr, input cpdi_addr_t a, input cpdi_word_t d);
      i_ext_rd = !cpu && !wr;
      i_ext_wr = !cpu && wr;
      i_cpu_rd = cpu && !wr;
      i_cpu_wr = cpu && wr;
      i_ext_addr = a;
      i_cpu_addr = a;
      i_ext_wdata = d;
      i_cpu_wdata = d;
      @(negedge i_ref_clk);
   endtask
   task automatic rd(input bit cpu, input cpdi_addr_t a, input cpdi_word_t exp);
      req(cpu, 1'b0, a, 14'h0000);
      chk("rvalid", 14'(cpu ? o_cpu_rvalid : o_ext_rvalid), 14'h0001);
      chk("rdata", cpu ? o_cpu_rdata : o_ext_rdata, exp);
   endtask

   // Hang guard, far above the hundred or so cycles the sequence needs
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end

   initial begin
      {i_rst_n, i_bulk_erase, i_ext_rd, i_ext_wr, i_cpu_rd, i_cpu_wr} = 6'h00;
      {i_ext_addr, i_cpu_addr, i_ext_wdata, i_cpu_wdata} = '0;
      i_read_protect_n = 1'b1;
      {i_config_region_write_lock_n, i_boot_region_write_lock_n} = 2'h3;
      {i_storage_region_write_lock_n, i_app_region_write_lock_n} = 2'h3;
      i_cpu_region = CPDI_REG_APP;
      repeat (16) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      chk("cp_word", o_cp_word, 14'h3FFF);
      rd(1'b0, DEV_ID_ADDR, PART);
      rd(1'b1, REV_ID_ADDR, REV);
      // Whole factory area from alternating ports
      for (int i = 0; i < 32; i++) begin
         rd(i[0], 16'h8100 + 16'(i), exp_info(i));
      end
      // Writes aimed at read-only words leave them intact
      req(1'b0, 1'b1, 16'h8006, 14'h0555);
      req(1'b1, 1'b1, 16'h8005, 14'h0555);
      req(1'b0, 1'b1, 16'h8100, 14'h0555);
      req(1'b1, 1'b1, 16'h8113, 14'h0555);
      rd(1'b1, 16'h8006, PART);
      rd(1'b0, 16'h8005, REV);
      rd(1'b1, 16'h8100, exp_info(0));
      rd(1'b0, 16'h8113, exp_info(19));
      // User words: written by one port, read by the other, then erased
      for (int i = 0; i < 4; i++) req(i[0], 1'b1, 16'h8000 + 16'(i), 14'h1100 + 14'(i));
      for (int i = 0; i < 4; i++) begin
         rd(!i[0], 16'h8000 + 16'(i), 14'h1100 + 14'(i));
      end
      i_bulk_erase = 1'b1;
      idle();
      i_bulk_erase = 1'b0;
      rd(1'b1, 16'h8002, 14'h3FFF);
      rd(1'b0, 16'h8100, exp_info(0));
      rd(1'b1, 16'h810A, exp_info(10));
      // Array access open, then closed by the protection bit
      req(1'b0, 1'b1, 16'h0003, 14'h1555);
      chk("ext_mem_wr", 14'(o_ext_mem_wr), 14'h0001);
      chk("mem_wdata", o_mem_wdata, 14'h1555);
      repeat (2) idle();
      rd(1'b0, 16'h0003, 14'h1555);
      i_read_protect_n = 1'b0;
      idle();
      chk("cp_word", o_cp_word, 14'h3FFE);
      req(1'b0, 1'b1, 16'h0004, 14'h0AAA);
      chk("ext_mem_wr", 14'(o_ext_mem_wr), 14'h0000);
      repeat (2) idle();
      rd(1'b0, 16'h0003, 14'h0000);
      rd(1'b1, 16'h0004, 14'h0104);
      rd(1'b1, 16'h0003, 14'h1555);
      rd(1'b0, 16'h8006, PART);
      // Each lock against each region of a self-write
      for (int r = 0; r < 4; r++) begin
         {i_config_region_write_lock_n, i_boot_region_write_lock_n,
          i_storage_region_write_lock_n, i_app_region_write_lock_n} = 4'hF ^ (4'h1 << r);
         for (int e = 0; e < 4; e++) begin
            i_cpu_region = cpdi_region_e'(e);
            req(1'b1, 1'b1, 16'h0005, 14'h2000 + 14'(e));
            chk("wr_blocked", 14'(o_cpu_wr_blocked), 14'(r == e));
            chk("cpu_mem_wr", 14'(o_cpu_mem_wr), 14'(r != e));
         end
      end
      wrap_up();
   end
endmodule
